/* typea_card_activation_fsm.sv */
/*
 * Card-side activation state machine for a Type A proximity card.
 * Frames arrive decoded on the carrier clock; the decision is taken on
 * the core clock; the answer start is timed in carrier periods.
 * Assumes a frame decoder and encoder on linkClk, and a free-running
 * carrier clock while the field is present.
 */
`timescale 1ns/1ps

module typea_card_activation_fsm
    import typea_act_pkg::*;
#(
    parameter uid_size_e UID_SIZE   = UID_DOUBLE, // static uid length
    parameter int        ATS_MAX_FC = 65536       // ATS delay bound, periods
) (
    input  wire logic        clk,       // core clock
    input  wire logic        rst_n,     // async reset, both domains
    input  wire logic        linkClk,   // carrier clock of the rf link
    input  wire logic        rxFrame,   // decoded frame pulse, linkClk
    input  wire rx_frame_s   rxData,    // decoded frame, with rxFrame
    output logic             txStart,   // answer start pulse, linkClk
    output tx_resp_s         txResp,    // answer to send, linkClk
    output card_state_e      cardState  // current card state, clk
);

    // ==========================================================
    // state carriers of the two domains
    typedef struct packed {
        card_state_e st;      // card state
        logic [2:0]  reqSync; // request toggle sync, [2] is last seen
        logic        ackTgl;  // decision ready toggle
        tx_resp_s    resp;    // decided answer, held for the link
    } core_s;

    typedef struct packed {
        logic                 reqTgl;  // frame request toggle
        rx_frame_s            frame;   // held frame for the core
        logic [2:0]           ackSync; // ack toggle sync, [2] last seen
        logic                 busy;    // frame delay running
        logic                 decided; // decision arrived for this frame
        logic [FDT_CNT_W-1:0] cnt;     // carrier periods since frame end
        logic [FDT_CNT_W-1:0] target;  // frame delay to reach
        tx_resp_s             resp;    // answer of this frame
        logic                 txStart; // answer start
    } link_s;

    core_s c_q;
    core_s c_d;
    link_s l_q;
    link_s l_d;

    // ==========================================================
    // core side decode of the held frame
    rx_frame_s   f;
    logic        reqEvt;
    logic        reqOk;
    logic        wakeOk;
    logic        inReady;
    logic [7:0]  expCode;
    logic        lvlHit;
    logic        acHit;
    logic        selHit;
    logic        ratsOk;
    logic        lastLvl;
    card_state_e nextLvl;

    // frame words are stable once the toggle is seen
    assign f      = l_q.frame;
    assign reqEvt = c_q.reqSync[2] ^ c_q.reqSync[1];
    // wake-up only counts in a short frame
    assign wakeOk = f.shortFrame && (f.cmd == CMD_WUPA);
    assign reqOk  = wakeOk || (f.shortFrame && (f.cmd == CMD_REQA));
    assign ratsOk = (f.cmd == CMD_RATS) && f.crcOk;
    assign acHit  = (f.cmd == CMD_AC) && lvlHit;
    assign selHit = (f.cmd == CMD_SEL) && lvlHit && f.crcOk;
    assign lvlHit = inReady && (f.selCode == expCode) && f.uidMatch;

    // select code, last level and next level per ready state
    always_comb begin
        inReady = 1'b1;
        expCode = SEL_CODE_CL1;
        lastLvl = (UID_SIZE == UID_SINGLE);
        nextLvl = ST_READY2;
        case (c_q.st)
            ST_READY1, ST_READY1W: begin
                expCode = SEL_CODE_CL1;
            end
            ST_READY2: begin
                expCode = SEL_CODE_CL2;
                lastLvl = (UID_SIZE == UID_DOUBLE);
                nextLvl = ST_READY3;
            end
            ST_READY3: begin
                expCode = SEL_CODE_CL3;
                lastLvl = 1'b1;
            end
            default: begin
                inReady = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // core decision: next state and answer for each frame
    always_comb begin
        c_d         = c_q;
        c_d.reqSync = {c_q.reqSync[1:0], l_q.reqTgl};
        if (reqEvt) begin
            c_d.ackTgl = ~c_q.ackTgl;
            c_d.resp   = '0;
            case (c_q.st)
                ST_IDLE: begin
                    if (reqOk) begin
                        c_d.resp.kind = RESP_ATQA;
                        c_d.st        = ST_READY1;
                    end
                end
                ST_READY1, ST_READY1W, ST_READY2, ST_READY3: begin
                    // any miss: silence and fall back
                    c_d.st = (c_q.st == ST_READY1W) ? ST_HALT : ST_IDLE;
                    if (acHit) begin
                        // uid tail, repeatable before select
                        c_d.resp.kind      = RESP_UID_TAIL;
                        c_d.resp.selCode   = f.selCode;
                        c_d.resp.tailStart = f.bitsSent;
                        c_d.resp.bccOnly   = (f.bitsSent == UID_LEVEL_FULL);
                        c_d.st             = c_q.st;
                    end else if (selHit) begin
                        c_d.resp.kind       = RESP_SAK;
                        c_d.resp.selCode    = f.selCode;
                        c_d.resp.sakCascade = ~lastLvl;
                        c_d.st = lastLvl ? ST_ACTIVE : nextLvl;
                    end
                end
                ST_ACTIVE: begin
                    if (ratsOk) begin
                        c_d.resp.kind = RESP_ATS;
                        c_d.st        = ST_PROTOCOL;
                    end else if (f.cmd == CMD_HLTA) begin
                        c_d.st = ST_HALT;
                    end else begin
                        c_d.st = ST_IDLE;
                    end
                end
                ST_HALT: begin
                    if (wakeOk) begin
                        c_d.resp.kind = RESP_ATQA;
                        c_d.st        = ST_READY1W;
                    end
                end
                ST_PROTOCOL: begin
                    c_d.st = ST_PROTOCOL;
                end
                default: begin
                    c_d.st = ST_IDLE;
                end
            endcase
        end
    end

    // core register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // ==========================================================
    // link side: frame capture, handshake and frame delay timer
    logic ackEvt;
    logic fdtDone;

    assign ackEvt  = l_q.ackSync[2] ^ l_q.ackSync[1];
    assign fdtDone = l_q.busy && (l_q.cnt == l_q.target);

    always_comb begin
        l_d         = l_q;
        l_d.txStart = 1'b0;
        l_d.ackSync = {l_q.ackSync[1:0], c_q.ackTgl};
        // take the core answer while the delay runs
        if (ackEvt && l_q.busy) begin
            l_d.resp    = c_q.resp;
            l_d.decided = 1'b1;
        end
        // count carrier periods, start the answer on the target
        if (l_q.busy) begin
            l_d.cnt = l_q.cnt + FDT_CNT_ONE;
            if (fdtDone) begin
                l_d.txStart = l_q.decided && (l_q.resp.kind != RESP_NONE);
                l_d.busy    = 1'b0;
            end
        end
        // a new frame restarts the delay from its end
        if (rxFrame) begin
            l_d.frame   = rxData;
            l_d.reqTgl  = ~l_q.reqTgl;
            l_d.busy    = 1'b1;
            l_d.decided = 1'b0;
            l_d.txStart = 1'b0;
            l_d.cnt     = FDT_CNT_ONE;
            l_d.target  = rxData.lastBit ? FDT_ONE_CYC : FDT_ZERO_CYC;
        end
    end

    // link register
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // outputs
    assign txStart   = l_q.txStart;
    assign txResp    = l_q.resp;
    assign cardState = c_q.st;

    // ==========================================================
    // checks on the core decision
    property p_r2_fallback;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_READY2) && !acHit && !selHit
        |=> (c_q.st == ST_IDLE) && (c_q.resp.kind == RESP_NONE);
    endproperty
    a_r2_fallback: assert property (p_r2_fallback)
        else $error("level 2 miss did not fall silent to idle");

    property p_r2_tail;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_READY2) && acHit
        |=> (c_q.st == ST_READY2) && (c_q.resp.kind == RESP_UID_TAIL)
            && (c_q.resp.bccOnly == ($past(f.bitsSent) == UID_LEVEL_FULL));
    endproperty
    a_r2_tail: assert property (p_r2_tail)
        else $error("level 2 anticollision answer wrong");

    property p_r2_select;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_READY2) && selHit
        |=> (c_q.resp.kind == RESP_SAK)
            && (c_q.resp.sakCascade == (UID_SIZE == UID_TRIPLE))
            && (c_q.st == ((UID_SIZE == UID_TRIPLE) ? ST_READY3 : ST_ACTIVE));
    endproperty
    a_r2_select: assert property (p_r2_select)
        else $error("level 2 select answer or target wrong");

    property p_r3_fallback;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_READY3) && !acHit && !selHit
        |=> (c_q.st == ST_IDLE) && (c_q.resp.kind == RESP_NONE);
    endproperty
    a_r3_fallback: assert property (p_r3_fallback)
        else $error("level 3 miss did not fall silent to idle");

    property p_r3_hit;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_READY3) && (acHit || selHit)
        |=> $past(acHit)
            ? ((c_q.st == ST_READY3) && (c_q.resp.kind == RESP_UID_TAIL))
            : ((c_q.st == ST_ACTIVE) && (c_q.resp.kind == RESP_SAK)
               && !c_q.resp.sakCascade);
    endproperty
    a_r3_hit: assert property (p_r3_hit)
        else $error("level 3 match handled wrongly");

    property p_active;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_ACTIVE)
        |=> (c_q.st == ($past(ratsOk) ? ST_PROTOCOL :
                        ($past(f.cmd) == CMD_HLTA) ? ST_HALT : ST_IDLE))
            && ((c_q.resp.kind == RESP_ATS) == $past(ratsOk));
    endproperty
    a_active: assert property (p_active)
        else $error("active state transition wrong");

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        reqEvt && (c_q.st == ST_HALT)
        |=> $past(wakeOk)
            ? ((c_q.st == ST_READY1W) && (c_q.resp.kind == RESP_ATQA))
            : ((c_q.st == ST_HALT) && (c_q.resp.kind == RESP_NONE));
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt state transition wrong");

    property p_no_level2_single;
        @(posedge clk) disable iff (!rst_n)
        (c_q.st == ST_READY2) |-> (UID_SIZE != UID_SINGLE);
    endproperty
    a_no_level2_single: assert property (p_no_level2_single)
        else $error("single uid card in level 2 ready");

    property p_sak_cascade;
        @(posedge clk) disable iff (!rst_n)
        (c_q.resp.kind == RESP_SAK) |-> (c_q.resp.sakCascade == (c_q.st != ST_ACTIVE));
    endproperty
    a_sak_cascade: assert property (p_sak_cascade)
        else $error("SAK cascade bit disagrees with card state");

    // ==========================================================
    // checks on the answer timing
    property p_fdt;
        @(posedge linkClk) disable iff (!rst_n)
        txStart |-> ($past(l_q.cnt) == $past(l_q.target))
            && ($past(l_q.target) ==
                ($past(l_q.frame.lastBit) ? FDT_ONE_CYC : FDT_ZERO_CYC));
    endproperty
    a_fdt: assert property (p_fdt)
        else $error("answer start not on the frame delay");

    property p_fdt_load;
        @(posedge linkClk) disable iff (!rst_n)
        rxFrame |=> l_q.busy && (l_q.cnt == FDT_CNT_ONE)
            && (l_q.target == ($past(rxData.lastBit) ? FDT_ONE_CYC : FDT_ZERO_CYC));
    endproperty
    a_fdt_load: assert property (p_fdt_load)
        else $error("frame delay not restarted on a frame end");

    property p_ats_bound;
        @(posedge linkClk) disable iff (!rst_n)
        txStart && (txResp.kind == RESP_ATS) |-> ($past(l_q.target) < ATS_MAX_FC);
    endproperty
    a_ats_bound: assert property (p_ats_bound)
        else $error("ATS later than its bound");

endmodule

/* typea_act_pkg.sv */
/*
 * Shared types and constants for the card-side activation controller:
 * command classes, answer kinds, card states, frame and answer carriers,
 * select codes and frame delay figures.
 * Assumes a front end that decodes reader frames into the frame carrier.
 */
package typea_act_pkg;

    // ==========================================================
    // command classes as delivered by the frame decoder
    typedef enum logic [3:0] {
        CMD_REQA, CMD_WUPA, CMD_HLTA, CMD_AC, CMD_SEL, CMD_RATS,
        CMD_PPS, CMD_IBLOCK, CMD_DESEL, CMD_OTHER
    } cmd_e;

    // answer kinds handed to the frame encoder
    typedef enum logic [2:0] {
        RESP_NONE, RESP_ATQA, RESP_UID_TAIL, RESP_SAK, RESP_ATS
    } resp_e;

    // uid length of the card
    typedef enum logic [1:0] {UID_SINGLE, UID_DOUBLE, UID_TRIPLE} uid_size_e;

    // card states; READY1W is the level 1 ready state reached by wake-up
    typedef enum logic [2:0] {
        ST_IDLE, ST_READY1, ST_READY2, ST_READY3, ST_ACTIVE, ST_PROTOCOL,
        ST_HALT, ST_READY1W
    } card_state_e;

    // ==========================================================
    // select codes per cascade level
    localparam logic [7:0] SEL_CODE_CL1 = 8'h93;
    localparam logic [7:0] SEL_CODE_CL2 = 8'h95;
    localparam logic [7:0] SEL_CODE_CL3 = 8'h97;
    // uid bits carried per cascade level
    localparam int         UID_LEVEL_BITS = 32;
    localparam logic [5:0] UID_LEVEL_FULL = 6'(UID_LEVEL_BITS);

    // frame delay, in carrier periods, after a last bit of zero or one
    localparam int FDT_ZERO_FC     = 1172;
    localparam int FDT_ONE_FC      = 1236;
    // the link clock is the carrier itself: one cycle per period
    localparam int LINK_CYC_PER_FC = 1;
    localparam int FDT_CNT_W       = 11;
    localparam logic [FDT_CNT_W-1:0] FDT_ZERO_CYC =
        FDT_CNT_W'(FDT_ZERO_FC * LINK_CYC_PER_FC);
    localparam logic [FDT_CNT_W-1:0] FDT_ONE_CYC =
        FDT_CNT_W'(FDT_ONE_FC * LINK_CYC_PER_FC);
    localparam logic [FDT_CNT_W-1:0] FDT_CNT_ONE = 11'h001;

    // ==========================================================
    // one decoded reader frame
    typedef struct packed {
        cmd_e       cmd;        // command class
        logic [7:0] selCode;    // select code of AC / SELECT
        logic       uidMatch;   // uid bits sent match this card
        logic       crcOk;      // crc of the frame is good
        logic       shortFrame; // frame was a 7-bit short frame
        logic       lastBit;    // value of the frame's last bit
        logic [5:0] bitsSent;   // uid bits the reader already sent
    } rx_frame_s;

    // one answer to send
    typedef struct packed {
        resp_e      kind;       // what to send
        logic       sakCascade; // cascade bit of SAK
        logic [7:0] selCode;    // level of a uid tail
        logic [5:0] tailStart;  // first uid bit of the tail
        logic       bccOnly;    // all 32 bits sent, answer BCC only
    } tx_resp_s;

endpackage

/* typea_reader_model.sv */
/*
 * Reader-side model for the card activation controller: sends decoded
 * frames on the carrier clock and times every answer start.
 * Assumes the caller drives frames one at a time through send.
 */
`timescale 1ns/1ps

module typea_reader_model
    import typea_act_pkg::*;
(
    input  wire logic      linkClk, // carrier clock
    input  wire logic      txStart, // answer start pulse from the card
    input  wire tx_resp_s  txResp,  // answer carried with txStart
    output logic           rxFrame, // frame end pulse to the card
    output rx_frame_s      rxData   // decoded frame to the card
);
    // ==========================================================
    // answer timing
    int       sinceFrame = 0; // carrier edges since the last frame end
    int       lastGap    = 0; // edges from frame end to answer start
    int       numTx      = 0; // answers seen so far
    tx_resp_s lastResp;       // last answer taken

    initial begin
        rxFrame = 1'b0;
        rxData  = '0;
    end

    // take the answer at the edge that sees the start pulse
    always @(posedge linkClk) begin
        sinceFrame <= (rxFrame === 1'b1) ? 0 : sinceFrame + 1;
        if (txStart === 1'b1) begin
            lastGap  <= sinceFrame;
            numTx    <= numTx + 1;
            lastResp <= txResp;
        end
    end

    // ==========================================================
    // one frame: a pulse, then the data lines no longer hold it
    task automatic send(input rx_frame_s f);
        @(posedge linkClk);
        #1;
        rxFrame = 1'b1;
        rxData  = f;
        @(posedge linkClk);
        #1;
        rxFrame = 1'b0;
        rxData  = ~f; // stale value is inverted so it is never reused
    endtask
endmodule

/* typea_card_activation_fsm_test.sv */
/*
 * Self-checking bench for the activation controller of a triple size
 * uid card, with a double size card on the same frames: a state table of
 * state transitions, two of them answered with a uid tail, then answer timing.
 * Assumes the reader model file is compiled before this one.
 */
`timescale 1ns/1ps

module typea_card_activation_fsm_test
    import typea_act_pkg::*;
;
    typedef struct packed {
        card_state_e from; // state to start in
        cmd_e        cmd;  // command class sent
        logic [7:0]  sel;  // select code
        logic [2:0]  mcs;  // uid match, crc good, short frame
        card_state_e exp;  // state expected afterwards
    } row_s;

    // ==========================================================
    // transition table
    localparam row_s ROWS [30] = '{
        '{ST_READY2, CMD_REQA, 8'h00, 3'h7, ST_IDLE}, '{ST_READY2, CMD_WUPA, 8'h00, 3'h7, ST_IDLE},
        '{ST_READY2, CMD_HLTA, 8'h00, 3'h6, ST_IDLE}, '{ST_READY2, CMD_AC, 8'h95, 3'h2, ST_IDLE},
        '{ST_READY2, CMD_SEL, 8'h95, 3'h2, ST_IDLE}, '{ST_READY2, CMD_SEL, 8'h95, 3'h4, ST_IDLE},
        '{ST_READY2, CMD_IBLOCK, 8'h00, 3'h6, ST_IDLE},
        '{ST_READY2, CMD_DESEL, 8'h00, 3'h6, ST_IDLE},
        '{ST_READY2, CMD_RATS, 8'h00, 3'h6, ST_IDLE}, '{ST_READY2, CMD_PPS, 8'h00, 3'h6, ST_IDLE},
        '{ST_READY2, CMD_AC, 8'h95, 3'h6, ST_READY2}, '{ST_READY3, CMD_REQA, 8'h00, 3'h7, ST_IDLE},
        '{ST_READY3, CMD_HLTA, 8'h00, 3'h6, ST_IDLE}, '{ST_READY3, CMD_AC, 8'h97, 3'h2, ST_IDLE},
        '{ST_READY3, CMD_SEL, 8'h97, 3'h4, ST_IDLE}, '{ST_READY3, CMD_DESEL, 8'h00, 3'h6, ST_IDLE},
        '{ST_READY3, CMD_PPS, 8'h00, 3'h6, ST_IDLE}, '{ST_READY3, CMD_AC, 8'h97, 3'h6, ST_READY3},
        '{ST_ACTIVE, CMD_WUPA, 8'h00, 3'h7, ST_IDLE}, '{ST_ACTIVE, CMD_SEL, 8'h93, 3'h6, ST_IDLE},
        '{ST_ACTIVE, CMD_RATS, 8'h00, 3'h4, ST_IDLE},
        '{ST_ACTIVE, CMD_IBLOCK, 8'h00, 3'h6, ST_IDLE},
        '{ST_ACTIVE, CMD_PPS, 8'h00, 3'h6, ST_IDLE}, '{ST_ACTIVE, CMD_HLTA, 8'h00, 3'h6, ST_HALT},
        '{ST_HALT, CMD_REQA, 8'h00, 3'h7, ST_HALT}, '{ST_HALT, CMD_HLTA, 8'h00, 3'h6, ST_HALT},
        '{ST_HALT, CMD_AC, 8'h93, 3'h6, ST_HALT}, '{ST_HALT, CMD_SEL, 8'h93, 3'h6, ST_HALT},
        '{ST_HALT, CMD_RATS, 8'h00, 3'h6, ST_HALT}, '{ST_HALT, CMD_WUPA, 8'h00, 3'h6, ST_HALT}
    };

    logic        clk;       // core clock
    logic        rst_n;     // async reset
    logic        linkClk;   // carrier clock
    logic        rxFrame;   // frame pulse
    rx_frame_s   rxData;    // decoded frame
    logic        txStart;   // answer start
    tx_resp_s    txResp;    // answer
    card_state_e cardState; // card state
    logic        txStartDbl;   // answer start, double size card
    tx_resp_s    txRespDbl;    // answer, double size card
    card_state_e cardStateDbl; // card state, double size card
    int          numErrors   = 0; // mismatches
    int          comparisons = 0; // checks made

    typea_card_activation_fsm #(.UID_SIZE(UID_TRIPLE), .ATS_MAX_FC(65536)) DUT (
        .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .rxFrame(rxFrame), .rxData(rxData),
        .txStart(txStart), .txResp(txResp), .cardState(cardState));

    typea_reader_model rdr (
        .linkClk(linkClk), .txStart(txStart), .txResp(txResp), .rxFrame(rxFrame),
        .rxData(rxData));

    // a double size uid card listening to the same frames
    typea_card_activation_fsm #(.UID_SIZE(UID_DOUBLE), .ATS_MAX_FC(65536)) DUT2 (
        .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .rxFrame(rxFrame), .rxData(rxData),
        .txStart(txStartDbl), .txResp(txRespDbl), .cardState(cardStateDbl));

    // ==========================================================
    // clocks: the carrier is offset so its edges wander against clk
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #7;
        forever #32 linkClk = ~linkClk;
    end

    // ==========================================================
    // helpers
    function automatic rx_frame_s mk(cmd_e c, logic [7:0] s, logic [2:0] mcs, logic lb,
                                     logic [5:0] b);
        mk = '{cmd: c, selCode: s, uidMatch: mcs[2], crcOk: mcs[1], shortFrame: mcs[0],
               lastBit: lb, bitsSent: b};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // state updates land well inside eight carrier cycles
    task automatic settle();
        repeat (8) @(posedge linkClk);
        @(posedge clk);
        #1;
    endtask

    task automatic reset_dut();
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        repeat (2) @(posedge linkClk);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge linkClk);
    endtask

    // walk up from reset; each frame cuts the previous answer short
    task automatic goto(input card_state_e s);
        rx_frame_s path [5];
        path = '{mk(CMD_REQA, 8'h00, 3'h7, 1'b0, 6'h00),
                 mk(CMD_SEL, SEL_CODE_CL1, 3'h6, 1'b0, 6'h20),
                 mk(CMD_SEL, SEL_CODE_CL2, 3'h6, 1'b0, 6'h20),
                 mk(CMD_SEL, SEL_CODE_CL3, 3'h6, 1'b0, 6'h20),
                 mk(CMD_HLTA, 8'h00, 3'h6, 1'b0, 6'h00)};
        reset_dut();
        chk(cardState, ST_IDLE);
        for (int i = 0; i < 5 && cardState !== s; i++) begin
            rdr.send(path[i]);
            settle();
        end
        chk(cardState, s);
    endtask

    // bounded wait for one answer, then its delay and kind
    task automatic wait_tx(input int gap, input resp_e kind);
        int n0;
        n0 = rdr.numTx;
        for (int k = 0; k < 1400 && rdr.numTx == n0; k++) begin
            @(posedge linkClk);
            #1;
        end
        if (rdr.numTx == n0) begin
            numErrors++;
            $display("ERROR %0t: no answer started", $time);
            end_of_test();
        end else begin
            chk(rdr.lastGap, gap);
            chk(rdr.lastResp.kind, kind);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        reset_dut();
        chk(cardState, ST_IDLE);
        chk({txStart, txStartDbl}, 2'b00);
        foreach (ROWS[i]) begin
            goto(ROWS[i].from);
            rdr.send(mk(ROWS[i].cmd, ROWS[i].sel, ROWS[i].mcs, 1'b0, 6'h10));
            settle();
            chk(cardState, ROWS[i].exp);
        end
        // full-length uid sent: answer is the check byte alone
        goto(ST_READY2);
        rdr.send(mk(CMD_AC, SEL_CODE_CL2, 3'h6, 1'b0, 6'h20));
        wait_tx(FDT_ZERO_FC, RESP_UID_TAIL);
        chk(rdr.lastResp.selCode, SEL_CODE_CL2);
        chk({rdr.lastResp.tailStart, rdr.lastResp.bccOnly}, {UID_LEVEL_FULL, 1'b1});
        rdr.send(mk(CMD_SEL, SEL_CODE_CL2, 3'h6, 1'b1, 6'h20));
        wait_tx(FDT_ONE_FC, RESP_SAK);
        chk(rdr.lastResp.sakCascade, 1'b1);
        chk({txRespDbl.kind, txRespDbl.sakCascade}, {RESP_SAK, 1'b0});
        chk(cardStateDbl, ST_ACTIVE);
        chk(cardState, ST_READY3);
        rdr.send(mk(CMD_SEL, SEL_CODE_CL3, 3'h6, 1'b0, 6'h20));
        wait_tx(FDT_ZERO_FC, RESP_SAK);
        chk({rdr.lastResp.sakCascade, cardState}, {1'b0, ST_ACTIVE});
        rdr.send(mk(CMD_RATS, 8'h00, 3'h6, 1'b0, 6'h00));
        wait_tx(FDT_ZERO_FC, RESP_ATS);
        chk(rdr.lastGap < 65536, 1'b1);
        chk(cardState, ST_PROTOCOL);
        // wake code in a standard frame, then in a short frame
        goto(ST_HALT);
        rdr.send(mk(CMD_WUPA, 8'h00, 3'h6, 1'b1, 6'h00));
        settle();
        chk(cardState, ST_HALT);
        rdr.send(mk(CMD_WUPA, 8'h00, 3'h7, 1'b1, 6'h00));
        wait_tx(FDT_ONE_FC, RESP_ATQA);
        chk(cardState, ST_READY1W);
        end_of_test();
    end
endmodule
